// File: logic/dual_leaky_bucket_policer.sv
// Functional notes
// - separate service and bundle tables of identical dual bucket entries
// - each entry holds a 2-bit rate scale selector
// - scale steps shift drain by three bits each, 16 kbps up to 8 Mbps
// - drop level at or below green ceiling is green, above is yellow
// - green ceiling of 3 makes the policer colour blind
// - one coupling bit per entry selects coupled or uncoupled buckets
// - committed overrun raises drop level by the excess increment
// - signed 7-bit size adjustment added to each frame length
// - each bucket rate is an 11-bit field
// - each burst threshold is 7 bits in 2 kilobyte units
// - traffic mask picks CPU bound, front port, or both
// - policing only when drain and fill enables are both set
// - common divider sets the base drain tick
// - sticky flag when any frame is dropped
// - sticky flag when a green frame passes without any rate overrun
// - sticky flag when committed rate is exceeded
// - sticky flag when peak rate is exceeded
// - dual leaky bucket metering per bandwidth profile
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "dlb_params.svh"
module dual_leaky_bucket_policer #(
  parameter int NUM_POL = 16,
  parameter int IW = 4,
  parameter int LEN_W = 14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire logic frm_valid,
  input wire logic frm_bundle,
  input wire logic [IW-1:0] frm_idx,
  input wire logic [LEN_W-1:0] frm_len,
  input wire logic [1:0] frm_dp,
  input wire logic frm_to_cpu,
  input wire logic frm_to_front,
  output logic res_valid_ff,
  output logic res_drop_ff,
  output logic [1:0] res_dp_ff
);
  dlb_pkg::pol_cfg_t pcfg_ff [2][NUM_POL];
  dlb_pkg::bkt_cfg_t bcfg_ff [2][NUM_POL][2];
  dlb_pkg::level_t lvl_ff [2][NUM_POL][2];
  logic drain_on_ff;
  logic fill_on_ff;
  logic [15:0] div_ff;
  logic [3:0] ev_ff;
  logic tick;
  logic police;
  logic upd;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;
  logic acc;
  logic done;
  logic map_ok;
  logic [31:0] rd_word;
  logic [3:0] a_tbl;
  logic [IW-1:0] a_idx;
  logic [1:0] a_word;
  logic a_t;
  logic [1:0] inc_cur;

  dlb_meter_if #(.LEN_W(LEN_W)) m_if ();

  dlb_meter u_meter (
    .m(m_if)
  );

  dlb_tick_gen #(.W(16)) u_tick (
    .clk(clk),
    .rst(rst),
    .div(div_ff),
    .tick_ff(tick)
  );

  function automatic logic [31:0] pack_pol(input dlb_pkg::pol_cfg_t p);
    logic [31:0] d;
    d = '0;
    d[`DLB_F_SCALE +: 2] = p.rate_scale_selector;
    d[`DLB_F_CEIL +: 2] = p.green_ceiling;
    d[`DLB_F_COUPLE] = p.coupling;
    d[`DLB_F_INC +: 2] = p.excess_increment;
    d[`DLB_F_GAP +: 7] = p.frame_size_adjustment;
    d[`DLB_F_MASK +: 2] = p.traffic_mask;
    return d;
  endfunction

  function automatic dlb_pkg::pol_cfg_t unpack_pol(input logic [31:0] d);
    dlb_pkg::pol_cfg_t p;
    p.rate_scale_selector = d[`DLB_F_SCALE +: 2];
    p.green_ceiling = d[`DLB_F_CEIL +: 2];
    p.coupling = d[`DLB_F_COUPLE];
    p.excess_increment = d[`DLB_F_INC +: 2];
    p.frame_size_adjustment = d[`DLB_F_GAP +: 7];
    p.traffic_mask = d[`DLB_F_MASK +: 2];
    return p;
  endfunction

  function automatic logic [31:0] pack_bkt(input dlb_pkg::bkt_cfg_t b);
    logic [31:0] d;
    d = '0;
    d[`DLB_F_RATE +: 11] = b.bucket_rate;
    d[`DLB_F_THR +: 7] = b.burst_threshold;
    return d;
  endfunction

  function automatic dlb_pkg::bkt_cfg_t unpack_bkt(input logic [31:0] d);
    dlb_pkg::bkt_cfg_t b;
    b.bucket_rate = d[`DLB_F_RATE +: 11];
    b.burst_threshold = d[`DLB_F_THR +: 7];
    return b;
  endfunction

  // drain by rate scaled by three bits per selector step
  function automatic dlb_pkg::level_t drained(input dlb_pkg::level_t v,
                                              input dlb_pkg::bkt_cfg_t b,
                                              input logic [1:0] sc);
    logic [3:0] sh;
    logic [20:0] amt;
    sh = {2'h0, sc} * `DLB_SCALE_STEP;
    amt = {10'h000, b.bucket_rate} << sh;
    return ({3'h0, v} > amt) ? 18'({3'h0, v} - amt) : '0;
  endfunction

  // meter sees the addressed entry and its current levels
  assign m_if.cfg = pcfg_ff[frm_bundle][frm_idx];
  assign m_if.b0 = bcfg_ff[frm_bundle][frm_idx][0];
  assign m_if.b1 = bcfg_ff[frm_bundle][frm_idx][1];
  assign m_if.lvl0 = lvl_ff[frm_bundle][frm_idx][0];
  assign m_if.lvl1 = lvl_ff[frm_bundle][frm_idx][1];
  assign m_if.len = frm_len;
  assign m_if.dp = frm_dp;
  assign inc_cur = m_if.cfg.excess_increment;

  assign police = frm_valid && drain_on_ff && fill_on_ff &&
                  |(m_if.cfg.traffic_mask & {frm_to_front, frm_to_cpu});
  assign upd = police && !m_if.drop;

  // frame result, one cycle after the frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_valid_ff <= 1'h0;
      res_drop_ff <= 1'h0;
      res_dp_ff <= 2'h0;
    end else begin
      res_valid_ff <= frm_valid;
      res_drop_ff <= police && m_if.drop;
      res_dp_ff <= police ? m_if.out_dp : frm_dp;
    end
  end

  // bucket levels: fill from the frame, then drain on tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int t = 0; t < 2; t++) begin
        for (int i = 0; i < NUM_POL; i++) begin
          lvl_ff[t][i][0] <= '0;
          lvl_ff[t][i][1] <= '0;
        end
      end
    end else begin
      for (int t = 0; t < 2; t++) begin
        for (int i = 0; i < NUM_POL; i++) begin
          for (int b = 0; b < 2; b++) begin
            if (upd && t == int'(frm_bundle) && i == int'(frm_idx)) begin
              if (tick && drain_on_ff) begin
                lvl_ff[t][i][b] <= drained(b == 1 ? m_if.new1 : m_if.new0,
                                           bcfg_ff[t][i][b],
                                           pcfg_ff[t][i].rate_scale_selector);
              end else begin
                lvl_ff[t][i][b] <= b == 1 ? m_if.new1 : m_if.new0;
              end
            end else if (tick && drain_on_ff) begin
              lvl_ff[t][i][b] <= drained(lvl_ff[t][i][b], bcfg_ff[t][i][b],
                                         pcfg_ff[t][i].rate_scale_selector);
            end
          end
        end
      end
    end
  end

  // apb decode
  assign acc = psel && penable && !pready_ff;
  assign done = psel && penable && pready_ff;
  assign a_tbl = paddr[11:8];
  assign a_idx = paddr[4 +: IW];
  assign a_word = paddr[3:2];
  assign a_t = a_tbl == `DLB_TBL_BUNDLE;

  always_comb begin
    map_ok = 1'h0;
    rd_word = '0;
    if (paddr == `DLB_OFS_CTRL) begin
      map_ok = 1'h1;
      rd_word[`DLB_F_DRAIN] = drain_on_ff;
      rd_word[`DLB_F_FILL] = fill_on_ff;
      rd_word[`DLB_F_DIV +: 16] = div_ff;
    end else if (paddr == `DLB_OFS_EVENTS) begin
      map_ok = 1'h1;
      rd_word[3:0] = ev_ff;
    end else if ((a_tbl == `DLB_TBL_SERVICE || a_t) && int'(paddr[7:4]) < NUM_POL &&
                 paddr[1:0] == 2'h0) begin
      case (a_word)
        `DLB_WORD_POLCFG: begin
          map_ok = 1'h1;
          rd_word = pack_pol(pcfg_ff[a_t][a_idx]);
        end
        `DLB_WORD_BKT0: begin
          map_ok = 1'h1;
          rd_word = pack_bkt(bcfg_ff[a_t][a_idx][0]);
        end
        `DLB_WORD_BKT1: begin
          map_ok = 1'h1;
          rd_word = pack_bkt(bcfg_ff[a_t][a_idx][1]);
        end
        default: begin
          map_ok = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_ff <= 1'h0;
      pslverr_ff <= 1'h0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc && !map_ok;
      prdata_ff <= (acc && !pwrite) ? rd_word : '0;
    end
  end

  // common control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drain_on_ff <= `DLB_DRAIN_RST;
      fill_on_ff <= `DLB_FILL_RST;
      div_ff <= `DLB_DIV_RST;
    end else if (done && pwrite && paddr == `DLB_OFS_CTRL) begin
      drain_on_ff <= pwdata[`DLB_F_DRAIN];
      fill_on_ff <= pwdata[`DLB_F_FILL];
      div_ff <= pwdata[`DLB_F_DIV +: 16];
    end
  end

  // per entry configuration tables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int t = 0; t < 2; t++) begin
        for (int i = 0; i < NUM_POL; i++) begin
          pcfg_ff[t][i] <= '0;
          bcfg_ff[t][i][0] <= '0;
          bcfg_ff[t][i][1] <= '0;
        end
      end
    end else if (done && pwrite && map_ok && a_tbl != 4'h0) begin
      case (a_word)
        `DLB_WORD_POLCFG: pcfg_ff[a_t][a_idx] <= unpack_pol(pwdata);
        `DLB_WORD_BKT0: bcfg_ff[a_t][a_idx][0] <= unpack_bkt(pwdata);
        `DLB_WORD_BKT1: bcfg_ff[a_t][a_idx][1] <= unpack_bkt(pwdata);
        default: ;
      endcase
    end
  end

  // sticky events, write one to clear, a new event wins
  assign ev_set[`DLB_EV_DROP] = police && m_if.drop;
  assign ev_set[`DLB_EV_OPEN] = police && m_if.open;
  assign ev_set[`DLB_EV_CIR] = police && m_if.cir_over;
  assign ev_set[`DLB_EV_PIR] = police && m_if.pir_over;
  assign ev_clr = (done && pwrite && paddr == `DLB_OFS_EVENTS) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_ff <= `DLB_EV_RST;
    end else begin
      ev_ff <= (ev_ff & ~ev_clr) | ev_set;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  drop_flag_a: assert property (res_valid_ff && res_drop_ff |-> ev_ff[`DLB_EV_DROP])
    else $error("drop without sticky drop flag");
  peak_flag_a: assert property (res_valid_ff && res_drop_ff |-> ev_ff[`DLB_EV_PIR])
    else $error("drop without peak over flag");
  sticky_hold_a: assert property (ev_ff[`DLB_EV_CIR] && !ev_clr[`DLB_EV_CIR]
    |=> ev_ff[`DLB_EV_CIR]) else $error("committed flag lost without clear");
  disabled_pass_a: assert property (frm_valid && !(drain_on_ff && fill_on_ff)
    |=> !res_drop_ff && res_dp_ff == $past(frm_dp)) else $error("policed while disabled");
  mask_pass_a: assert property (frm_valid &&
    (m_if.cfg.traffic_mask & {frm_to_front, frm_to_cpu}) == 2'h0
    |=> res_valid_ff && !res_drop_ff) else $error("unselected traffic policed");
  dp_raise_a: assert property (police && m_if.cir_over && !m_if.drop
    |=> res_dp_ff == dlb_pkg::sat_dp($past(frm_dp), $past(inc_cur)))
    else $error("drop level not raised by increment");
  blind_green_a: assert property (police && m_if.cfg.green_ceiling == `DLB_CEIL_BLIND &&
    {1'h0, m_if.lvl0} + {1'h0, 18'(frm_len)} <= {1'h0, m_if.b0.burst_threshold, 11'h000}
    && m_if.cfg.frame_size_adjustment == 7'h00
    |=> !res_drop_ff && res_dp_ff == $past(frm_dp)) else $error("blind frame not green");
  over_drop_a: assert property (police && m_if.cfg.frame_size_adjustment == 7'h00 &&
    {1'h0, m_if.lvl1} + {1'h0, 18'(frm_len)} > {1'h0, m_if.b1.burst_threshold, 11'h000} &&
    (frm_dp > m_if.cfg.green_ceiling ||
     {1'h0, m_if.lvl0} + {1'h0, 18'(frm_len)} > {1'h0, m_if.b0.burst_threshold, 11'h000})
    |=> res_drop_ff) else $error("excess frame not dropped");
  fill_level_a: assert property (upd && m_if.open && !(tick && drain_on_ff) &&
    m_if.cfg.frame_size_adjustment == 7'h00
    |=> lvl_ff[$past(frm_bundle)][$past(frm_idx)][0] == $past(m_if.lvl0) + 18'($past(frm_len)))
    else $error("committed bucket not filled");

  drop_seen_c: cover property (res_valid_ff && res_drop_ff);
  yellow_pass_c: cover property (police && m_if.cir_over && !m_if.drop);
  green_pass_c: cover property (police && m_if.open && m_if.cfg.coupling);
  clear_race_c: cover property (|(ev_set & ev_clr));
endmodule

// File: logic/dlb_params.svh
`ifndef DLB_PARAMS_SVH
`define DLB_PARAMS_SVH

// register byte offsets, table selects and word indices
`define DLB_OFS_CTRL 12'h000
`define DLB_OFS_EVENTS 12'h004
`define DLB_TBL_SERVICE 4'h1
`define DLB_TBL_BUNDLE 4'h2
`define DLB_WORD_POLCFG 2'h0
`define DLB_WORD_BKT0 2'h1
`define DLB_WORD_BKT1 2'h2

// policer_config field positions
`define DLB_F_SCALE 0
`define DLB_F_CEIL 2
`define DLB_F_COUPLE 4
`define DLB_F_INC 5
`define DLB_F_GAP 7
`define DLB_F_MASK 14

// bucket_config field positions
`define DLB_F_RATE 0
`define DLB_F_THR 16

// common_policer_control field positions
`define DLB_F_DRAIN 0
`define DLB_F_FILL 1
`define DLB_F_DIV 16

// common_policer_events bit positions
`define DLB_EV_DROP 0
`define DLB_EV_OPEN 1
`define DLB_EV_CIR 2
`define DLB_EV_PIR 3

// reset values
`define DLB_DRAIN_RST 1'h0
`define DLB_FILL_RST 1'h0
`define DLB_DIV_RST 16'h0031
`define DLB_EV_RST 4'h0

// arithmetic constants
`define DLB_THR_UNIT_BITS 11'h000
`define DLB_SCALE_STEP 4'h3
`define DLB_CEIL_BLIND 2'h3

`endif

// File: logic/dlb_pkg.sv
package dlb_pkg;

  typedef logic [17:0] level_t;

  typedef struct packed {
    logic [1:0] traffic_mask;
    logic [6:0] frame_size_adjustment;
    logic [1:0] excess_increment;
    logic coupling;
    logic [1:0] green_ceiling;
    logic [1:0] rate_scale_selector;
  } pol_cfg_t;

  typedef struct packed {
    logic [6:0] burst_threshold;
    logic [10:0] bucket_rate;
  } bkt_cfg_t;

  function automatic logic [1:0] sat_dp(input logic [1:0] dp, input logic [1:0] inc);
    logic [2:0] s;
    s = {1'h0, dp} + {1'h0, inc};
    return s[2] ? 2'h3 : s[1:0];
  endfunction

endpackage

// File: logic/dlb_meter_if.sv
`timescale 1ns/100ps
interface dlb_meter_if #(parameter int LEN_W = 14);
  dlb_pkg::pol_cfg_t cfg;
  dlb_pkg::bkt_cfg_t b0;
  dlb_pkg::bkt_cfg_t b1;
  dlb_pkg::level_t lvl0;
  dlb_pkg::level_t lvl1;
  logic [LEN_W-1:0] len;
  logic [1:0] dp;
  dlb_pkg::level_t new0;
  dlb_pkg::level_t new1;
  logic drop;
  logic cir_over;
  logic pir_over;
  logic open;
  logic [1:0] out_dp;

  modport core (
    output cfg, b0, b1, lvl0, lvl1, len, dp,
    input new0, new1, drop, cir_over, pir_over, open, out_dp
  );
  modport meter (
    input cfg, b0, b1, lvl0, lvl1, len, dp,
    output new0, new1, drop, cir_over, pir_over, open, out_dp
  );
endinterface

// File: logic/dlb_meter.sv
`timescale 1ns/100ps
`include "dlb_params.svh"
module dlb_meter (
  dlb_meter_if.meter m
);
  logic signed [15:0] adj;
  dlb_pkg::level_t size;
  dlb_pkg::level_t thr0;
  dlb_pkg::level_t thr1;
  logic [18:0] sum0;
  logic [18:0] sum1;
  logic fit0;
  logic fit1;
  logic green;

  // signed gap may shrink the counted size, never below zero
  assign adj = $signed({2'h0, m.len}) + 16'(signed'(m.cfg.frame_size_adjustment));
  assign size = adj[15] ? '0 : {2'h0, adj};
  assign thr0 = {m.b0.burst_threshold, `DLB_THR_UNIT_BITS};
  assign thr1 = {m.b1.burst_threshold, `DLB_THR_UNIT_BITS};
  assign sum0 = {1'h0, m.lvl0} + {1'h0, size};
  assign sum1 = {1'h0, m.lvl1} + {1'h0, size};
  assign fit0 = sum0 <= {1'h0, thr0};
  assign fit1 = sum1 <= {1'h0, thr1};
  assign green = (m.cfg.green_ceiling == `DLB_CEIL_BLIND) ||
                 (m.dp <= m.cfg.green_ceiling);

  // committed bucket first for green, second bucket for the rest
  always_comb begin
    m.new0 = m.lvl0;
    m.new1 = m.lvl1;
    m.drop = 1'h0;
    m.cir_over = 1'h0;
    m.pir_over = 1'h0;
    m.open = 1'h0;
    m.out_dp = m.dp;
    if (green && fit0) begin
      m.new0 = sum0[17:0];
      m.open = 1'h1;
      if (m.cfg.coupling) begin
        // coupled second bucket also carries committed traffic
        m.new1 = fit1 ? sum1[17:0] : thr1;
      end
    end else if (fit1) begin
      m.new1 = sum1[17:0];
      if (green) begin
        m.cir_over = 1'h1;
        m.out_dp = dlb_pkg::sat_dp(m.dp, m.cfg.excess_increment);
      end
    end else begin
      m.drop = 1'h1;
      m.pir_over = 1'h1;
      m.cir_over = green;
    end
  end
endmodule

// File: logic/dlb_tick_gen.sv
`timescale 1ns/100ps
module dlb_tick_gen #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] div,
  output logic tick_ff
);
  logic [W-1:0] cnt_ff;

  // one pulse every div+1 cycles sets the base unit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      tick_ff <= 1'h0;
    end else if (cnt_ff >= div) begin
      cnt_ff <= '0;
      tick_ff <= 1'h1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      tick_ff <= 1'h0;
    end
  end

  property tick_spacing_p;
    @(posedge clk) disable iff (rst)
      tick_ff && (div != '0) && $stable(div) |=> !tick_ff;
  endproperty
  tick_spacing_a: assert property (tick_spacing_p) else $error("tick pulses too close");
endmodule

// File: sim/frame_source.sv
`timescale 1ns/100ps
module frame_source (
  input wire logic clk,
  output logic frm_valid,
  output logic frm_bundle,
  output logic [3:0] frm_idx,
  output logic [13:0] frm_len,
  output logic [1:0] frm_dp,
  output logic frm_to_cpu,
  output logic frm_to_front
);
  initial begin
    frm_valid = 1'h0;
    frm_bundle = 1'h0;
    frm_idx = 4'h0;
    frm_len = 14'h0000;
    frm_dp = 2'h0;
    frm_to_cpu = 1'h0;
    frm_to_front = 1'h0;
  end

  // one frame per call; calls in a row give back-to-back frames
  task automatic send(input logic b, input logic [3:0] i, input logic [13:0] l,
                      input logic [1:0] d, input logic c, input logic f);
    @(posedge clk);
    frm_valid <= 1'h1;
    frm_bundle <= b;
    frm_idx <= i;
    frm_len <= l;
    frm_dp <= d;
    frm_to_cpu <= c;
    frm_to_front <= f;
  endtask

  // fields carry junk between frames
  task automatic idle();
    @(posedge clk);
    frm_valid <= 1'h0;
    frm_idx <= ~frm_idx;
    frm_len <= ~frm_len;
    frm_dp <= ~frm_dp;
    frm_to_cpu <= ~frm_to_cpu;
  endtask
endmodule

// File: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk, rst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_ff;
  logic pready_ff, pslverr_ff, frm_valid, frm_bundle, frm_to_cpu, frm_to_front;
  logic [3:0] frm_idx;
  logic [13:0] frm_len;
  logic [1:0] frm_dp, res_dp_ff;
  logic res_valid_ff, res_drop_ff;
  int fail_count = 0;
  int num_checks = 0;
  int seed = 36199;
  logic [3:0] fq[$];
  logic [32:0] rq[$];

  dual_leaky_bucket_policer dual_leaky_bucket_policer_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .frm_valid(frm_valid), .frm_bundle(frm_bundle), .frm_idx(frm_idx), .frm_len(frm_len),
    .frm_dp(frm_dp), .frm_to_cpu(frm_to_cpu), .frm_to_front(frm_to_front),
    .res_valid_ff(res_valid_ff), .res_drop_ff(res_drop_ff), .res_dp_ff(res_dp_ff));
  frame_source frame_source_i (.clk(clk), .frm_valid(frm_valid), .frm_bundle(frm_bundle),
    .frm_idx(frm_idx), .frm_len(frm_len), .frm_dp(frm_dp), .frm_to_cpu(frm_to_cpu),
    .frm_to_front(frm_to_front));

  initial clk = 1'h0;
  always #10 clk = ~clk;

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // expectation {dp_matters, drop, dp}
  task automatic check_frame(input logic [3:0] e, input logic g_drop, input logic [1:0] g_dp);
    num_checks++;
    if (g_drop !== e[2] || (e[3] && g_dp !== e[1:0])) begin
      $display("Error frame result exp %h got %h", e[2:0], {g_drop, g_dp});
      fail_count++;
    end
  endtask

  task automatic check_rd(input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e) begin
      $display("Error apb response exp %h got %h", e, g);
      fail_count++;
    end
  endtask

  always @(posedge clk) begin
    if (res_valid_ff === 1'h1) begin
      if (fq.size() == 0) begin
        $display("Error frame result exp none got %h", {res_drop_ff, res_dp_ff});
        fail_count++;
      end else begin
        check_frame(fq.pop_front(), res_drop_ff, res_dp_ff);
      end
    end
    if (psel && penable && pready_ff === 1'h1 && rq.size() > 0) begin
      check_rd(rq.pop_front(), {pslverr_ff, prdata_ff});
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (int n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready_ff === 1'h1) break;
      if (n == 19) begin
        $display("Error pready exp 1 got %b", pready_ff);
        fail_count++;
        results();
      end
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    rq.push_back({1'h0, 32'h00000000});
    apb(1'h1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    rq.push_back({err, e});
    apb(1'h0, a, 32'h00000000);
  endtask

  task automatic fr(input logic b, input logic [3:0] i, input logic [13:0] l,
                    input logic [1:0] d, input logic c, input logic f, input logic [3:0] e);
    fq.push_back(e);
    frame_source_i.send(b, i, l, d, c, f);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    $display("Error watchdog exp done got hang");
    fail_count++;
    results();
  end

  initial begin
    logic [1:0] d;
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rd(12'h000, 32'h00310000, 1'h0);
    rd(12'h004, 32'h00000000, 1'h0);
    rd(12'h0F0, 32'h00000000, 1'h1);
    rd(12'h102, 32'h00000000, 1'h1);
    $display("test reset and map done");
    wr(12'h100, 32'h0000F424);
    wr(12'h104, 32'h00010000);
    wr(12'h108, 32'h00010000);
    rd(12'h100, 32'h0000F424, 1'h0);
    rd(12'h108, 32'h00010000, 1'h0);
    wr(12'h110, 32'h00004000);
    wr(12'h230, 32'h0000C01C);
    wr(12'h234, 32'h00010000);
    wr(12'h238, 32'h00020000);
    wr(12'h120, 32'h0000C001);
    wr(12'h124, 32'h0001000D);
    fr(1'h0, 4'h1, 14'h0064, 2'h1, 1'h1, 1'h0, 4'h9);
    frame_source_i.idle();
    wr(12'h000, 32'h00030003);
    $display("test config done");
    for (int k = 0; k < 6; k++) begin
      fr(1'h0, 4'h0, 14'h0400, (k == 5) ? 2'h2 : 2'h0, 1'h0, 1'h1,
         (k < 2) ? 4'h8 : (k < 4) ? 4'h9 : 4'h4);
    end
    // coupled: green fills also load the second bucket, so the fifth frame drops
    for (int k = 0; k < 5; k++) begin
      fr(1'h1, 4'h3, 14'h0400, 2'h3, 1'h1, 1'h0, (k < 4) ? 4'hB : 4'h4);
    end
    fr(1'h0, 4'h1, 14'h0064, 2'h2, 1'h0, 1'h1, 4'hA);
    fr(1'h0, 4'h1, 14'h0064, 2'h0, 1'h1, 1'h0, 4'h4);
    fr(1'h0, 4'h2, 14'h0800, 2'h0, 1'h1, 1'h1, 4'h8);
    fr(1'h0, 4'h2, 14'h00C8, 2'h0, 1'h1, 1'h1, 4'h4);
    frame_source_i.idle();
    $display("test metering done");
    repeat (40) @(posedge clk);
    fr(1'h0, 4'h2, 14'h0320, 2'h0, 1'h1, 1'h1, 4'h8);
    for (int k = 0; k < 8; k++) begin
      d = 2'($random(seed));
      fr(1'h0, 4'h5, 14'($random(seed)), d, 1'($random(seed)), 1'h1, {2'h2, d});
    end
    frame_source_i.idle();
    $display("test drain and random done");
    rd(12'h004, 32'h0000000F, 1'h0);
    rd(12'h004, 32'h0000000F, 1'h0);
    wr(12'h004, 32'h0000000F);
    rd(12'h004, 32'h00000000, 1'h0);
    repeat (3) @(posedge clk);
    if (fq.size() != 0 || rq.size() != 0) begin
      $display("Error pending results exp 0 got %0d", fq.size() + rq.size());
      fail_count++;
    end
    $display("test events done");
    results();
  end
endmodule
